// file: include/ebm_pkg.sv
// Package with constants and carrier types of the external bus chip-select mux.
package ebm_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] EBM_SELECT_OFFSET = 8'h00;
  localparam logic [7:0] EBM_STATUS_OFFSET = 8'h04;
  localparam logic [31:0] EBM_SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] EBM_SELECT_WMASK = 32'h0000_003e;
  localparam int EBM_DRAM_BIT = 1;
  localparam int EBM_NAND2_BIT = 2;
  localparam int EBM_NAND3_BIT = 3;
  localparam int EBM_CARD4_BIT = 4;
  localparam int EBM_CARD5_BIT = 5;

  // ----------------------------------------------------------------------
  // Bus widths and counts
  // ----------------------------------------------------------------------
  localparam int EBM_DATA_W = 16;
  localparam int EBM_ADDR_W = 24;
  localparam int EBM_NCS = 6;
  localparam int EBM_FLOAT_W = 4;
  localparam logic [3:0] EBM_FLOAT_RESET = 4'h0;

  // Card mode field in transfer address bits 23..21.
  localparam int EBM_MODE_MSB = 23;
  localparam int EBM_MODE_LSB = 21;
  localparam logic [2:0] EBM_MODE_ATTR = 3'h0;
  localparam logic [2:0] EBM_MODE_COMMON = 3'h2;
  localparam logic [2:0] EBM_MODE_IO = 3'h4;
  localparam logic [2:0] EBM_MODE_IDE = 3'h6;
  localparam logic [2:0] EBM_MODE_ALT_IDE = 3'h7;

  // Owner of the shared pins.
  typedef enum logic [1:0] {
    EBM_OWN_STATIC = 2'b00,
    EBM_OWN_DRAM = 2'b01,
    EBM_OWN_NAND = 2'b10
  } ebm_owner_t;

  // Pin behaviour of one access.
  typedef enum logic [1:0] {
    EBM_KIND_STATIC = 2'b00,
    EBM_KIND_DRAM = 2'b01,
    EBM_KIND_NAND = 2'b10,
    EBM_KIND_CARD = 2'b11
  } ebm_kind_t;

  // Pin set that one controller wants to drive.
  typedef struct packed {
    logic active;
    logic [EBM_ADDR_W-1:0] addr;
    logic [EBM_NCS-1:0] cs_n;
    logic rd_n;
    logic we0_n;
    logic we1_n;
    logic data_oe_n;
    logic [EBM_DATA_W-1:0] data;
  } ebm_pins_t;

  // Card strobes.
  typedef struct packed {
    logic ce1_n;
    logic ce2_n;
    logic noe_n;
    logic nwe_n;
    logic niord_n;
    logic rnw;
  } ebm_card_t;

endpackage : ebm_pkg

// file: rtl/ebm_float_gap.sv
// Counter that holds off a new owner of the data pins for the float time.
`timescale 1ns/10ps
`default_nettype none
module ebm_float_gap
  import ebm_pkg::*;
#(
  parameter int FLOAT_W = EBM_FLOAT_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic [FLOAT_W-1:0] float_cycles_i,
  // Status
  output logic busy_o
);

  typedef struct packed {
    logic [FLOAT_W-1:0] count;
    logic busy;
  } ebm_gap_state_t;

  ebm_gap_state_t state_reg;
  ebm_gap_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (start_i) begin
      state_next.count = float_cycles_i;
      state_next.busy = (float_cycles_i != '0);
    end else if (state_reg.busy) begin
      state_next.count = state_reg.count - 1'b1;
      state_next.busy = (state_reg.count > 1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy_o = state_reg.busy;

endmodule : ebm_float_gap
`default_nettype wire

// file: rtl/ebm_cs_mux.sv
// Chip-select assignment register and shared pin multiplexer of the external bus.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Select bit 5 set makes chip-select 5 accesses use card pin behaviour.
// - Select bit 4 chooses static or card pin behaviour for chip-select 4.
// - Select bit 3 set makes chip-select 3 accesses use NAND pin behaviour.
// - Select bit 2 set makes chip-select 2 accesses use NAND pin behaviour.
// - Select bit 1 set routes chip-select 1 to DRAM pin behaviour.
// - Address and output control lines stay stable while no access runs.
// - Data pins pass from a still-driving owner to a new one only after the old owner's float time.
// - DRAM refresh runs alone and never delays other controllers.
// - One 16-bit data bus and 24-bit address bus, chosen by area.
// - Two interrupt lines: one from DRAM, one from the ECC engine.
// - Card logic serves only chip-select 4 and 5 transfers.
// - Card modes supported; no IO write, IO16 or ATA select handling.
// - Address bits 23..21 pick attribute, common, IO, IDE or alternate IDE.
// - In card mode the chip-select pin carries only the card select.
module ebm_cs_mux
  import ebm_pkg::*;
#(
  parameter int FLOAT_W = EBM_FLOAT_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Controller pin requests
  input wire ebm_pins_t static_pins_i,
  input wire ebm_pins_t dram_pins_i,
  input wire ebm_pins_t nand_pins_i,
  input wire logic dram_refresh_i,
  input wire logic [FLOAT_W-1:0] static_float_i,
  input wire logic [FLOAT_W-1:0] dram_float_i,
  input wire logic [FLOAT_W-1:0] nand_float_i,
  // Controller interrupts
  input wire logic dram_irq_i,
  input wire logic ecc_irq_i,
  // Shared external pins
  output logic [EBM_ADDR_W-1:0] ext_addr_o,
  output logic [EBM_NCS-1:0] ext_chip_select_n_o,
  output logic ext_rd_n_o,
  output logic ext_we0_n_o,
  output logic ext_we1_n_o,
  output logic [EBM_DATA_W-1:0] ext_data_o,
  output logic ext_data_oe_n_o,
  output ebm_card_t card_o,
  // Status toward controllers and interrupt controller
  output logic dram_enable_o,
  output logic static_grant_o,
  output logic nand_grant_o,
  output logic dram_irq_line_o,
  output logic ecc_irq_line_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] select;
    logic [31:0] rdata;
    logic ack;
    ebm_owner_t owner;
    ebm_owner_t last_driver;
    logic [EBM_ADDR_W-1:0] addr;
    logic [EBM_NCS-1:0] cs_n;
    logic rd_n;
    logic we0_n;
    logic we1_n;
    logic [EBM_DATA_W-1:0] data;
    logic data_oe_n;
    ebm_card_t card;
    logic static_grant;
    logic nand_grant;
    logic dram_irq;
    logic ecc_irq;
  } ebm_state_t;

  ebm_state_t state_reg;
  ebm_state_t state_next;

  logic gap_busy;
  logic gap_start;
  logic [FLOAT_W-1:0] gap_cycles;

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  // Kind of pin behaviour for the lowest active chip select whose select bit is set.
  function automatic ebm_kind_t cs_kind(input logic [EBM_NCS-1:0] cs_n,
                                        input logic [31:0] sel);
    ebm_kind_t k;
    k = EBM_KIND_STATIC;
    if (!cs_n[1] && sel[EBM_DRAM_BIT]) begin
      k = EBM_KIND_DRAM;
    end else if ((!cs_n[2] && sel[EBM_NAND2_BIT]) || (!cs_n[3] && sel[EBM_NAND3_BIT])) begin
      k = EBM_KIND_NAND;
    end else if ((!cs_n[4] && sel[EBM_CARD4_BIT]) || (!cs_n[5] && sel[EBM_CARD5_BIT])) begin
      k = EBM_KIND_CARD;
    end
    return k;
  endfunction : cs_kind

  // Card strobes from the static strobes and the mode field.
  function automatic ebm_card_t card_strobes(input ebm_pins_t p, input logic [2:0] mode);
    ebm_card_t c;
    c.rnw = p.we0_n;
    c.ce1_n = p.addr[0];
    c.ce2_n = p.we1_n;
    c.noe_n = 1'b1;
    c.nwe_n = 1'b1;
    c.niord_n = 1'b1;
    unique case (mode)
      EBM_MODE_ATTR, EBM_MODE_COMMON: begin
        c.noe_n = p.rd_n;
        c.nwe_n = p.we0_n;
      end
      EBM_MODE_IO: begin
        c.niord_n = p.rd_n;
      end
      EBM_MODE_IDE: begin
        c.noe_n = 1'b0;
        c.niord_n = p.rd_n;
        c.ce1_n = 1'b0;
        c.ce2_n = 1'b1;
      end
      EBM_MODE_ALT_IDE: begin
        c.noe_n = 1'b0;
        c.niord_n = p.rd_n;
        c.ce1_n = 1'b1;
        c.ce2_n = 1'b0;
      end
      default: begin
        c.ce1_n = 1'b1;
        c.ce2_n = 1'b1;
      end
    endcase
    return c;
  endfunction : card_strobes

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  ebm_kind_t st_kind;
  ebm_kind_t nd_kind;
  logic wb_req;
  logic want_static;
  logic want_nand;
  logic want_dram;
  ebm_pins_t pick;
  ebm_owner_t want_owner;
  logic [31:0] wmask;

  always_comb begin
    st_kind = cs_kind(static_pins_i.cs_n, state_reg.select);
    nd_kind = cs_kind(nand_pins_i.cs_n, state_reg.select);
    wb_req = wb_cyc_i && wb_stb_i && !state_reg.ack;
    want_dram = dram_pins_i.active && state_reg.select[EBM_DRAM_BIT];
    want_static = static_pins_i.active && (st_kind != EBM_KIND_NAND);
    want_nand = nand_pins_i.active && (nd_kind == EBM_KIND_NAND);
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    state_next = state_reg;
    gap_start = 1'b0;
    gap_cycles = '0;
    pick = static_pins_i;
    want_owner = state_reg.owner;

    // Wishbone slave: one wait-free cycle, unmapped reads return zero.
    state_next.ack = wb_req;
    state_next.rdata = 32'h0000_0000;
    if (wb_req && wb_we_i && wb_adr_i == EBM_SELECT_OFFSET) begin
      state_next.select = (state_reg.select & ~(wmask & EBM_SELECT_WMASK))
                        | (wb_dat_i & wmask & EBM_SELECT_WMASK);
    end
    if (wb_req && !wb_we_i) begin
      if (wb_adr_i == EBM_SELECT_OFFSET) begin
        state_next.rdata = state_reg.select & EBM_SELECT_WMASK;
      end else if (wb_adr_i == EBM_STATUS_OFFSET) begin
        state_next.rdata = {27'h0000000, gap_busy, state_reg.owner, state_reg.data_oe_n,
                            dram_refresh_i};
      end
    end

    // Area arbitration; a pure refresh keeps the DRAM pins off the shared bus.
    if (want_static) begin
      want_owner = EBM_OWN_STATIC;
    end else if (want_nand) begin
      want_owner = EBM_OWN_NAND;
    end else if (want_dram && !dram_refresh_i) begin
      want_owner = EBM_OWN_DRAM;
    end

    // Hold the new owner off while the previous driver floats the data pins.
    if (want_owner != state_reg.last_driver && !state_reg.data_oe_n) begin
      gap_start = 1'b1;
      unique case (state_reg.last_driver)
        EBM_OWN_STATIC: gap_cycles = static_float_i;
        EBM_OWN_DRAM: gap_cycles = dram_float_i;
        EBM_OWN_NAND: gap_cycles = nand_float_i;
        default: gap_cycles = static_float_i;
      endcase
      state_next.data_oe_n = 1'b1;
    end
    state_next.owner = want_owner;

    unique case (want_owner)
      EBM_OWN_DRAM: pick = dram_pins_i;
      EBM_OWN_NAND: pick = nand_pins_i;
      default: pick = static_pins_i;
    endcase

    state_next.static_grant = want_static && (want_owner == EBM_OWN_STATIC);
    state_next.nand_grant = want_nand && (want_owner == EBM_OWN_NAND);

    if (want_static || want_nand || (want_dram && !dram_refresh_i)) begin
      state_next.addr = pick.addr;
      state_next.cs_n = pick.cs_n;
      state_next.rd_n = pick.rd_n;
      state_next.we0_n = pick.we0_n;
      state_next.we1_n = pick.we1_n;
      state_next.data = pick.data;
      if (!gap_start && !gap_busy) begin
        state_next.data_oe_n = pick.data_oe_n;
        if (!pick.data_oe_n) begin
          state_next.last_driver = want_owner;
        end
      end
      if (want_owner == EBM_OWN_STATIC && st_kind == EBM_KIND_CARD) begin
        state_next.card = card_strobes(pick, pick.addr[EBM_MODE_MSB:EBM_MODE_LSB]);
        state_next.rd_n = 1'b1;
        state_next.we0_n = 1'b1;
        state_next.we1_n = state_next.card.niord_n;
      end else begin
        state_next.card = '{ce1_n: 1'b1, ce2_n: 1'b1, noe_n: 1'b1, nwe_n: 1'b1,
                            niord_n: 1'b1, rnw: 1'b1};
      end
    end else begin
      // Idle: address kept, strobes inactive.
      state_next.cs_n = '1;
      state_next.rd_n = 1'b1;
      state_next.we0_n = 1'b1;
      state_next.we1_n = 1'b1;
      state_next.data_oe_n = 1'b1;
      state_next.card = '{ce1_n: 1'b1, ce2_n: 1'b1, noe_n: 1'b1, nwe_n: 1'b1,
                          niord_n: 1'b1, rnw: state_reg.card.rnw};
    end

    // In card mode the select pins carry only card selects.
    if (state_reg.select[EBM_CARD4_BIT] && want_owner != EBM_OWN_STATIC) begin
      state_next.cs_n[4] = 1'b1;
    end
    if (state_reg.select[EBM_CARD5_BIT] && want_owner != EBM_OWN_STATIC) begin
      state_next.cs_n[5] = 1'b1;
    end

    state_next.dram_irq = dram_irq_i;
    state_next.ecc_irq = ecc_irq_i;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.select <= EBM_SELECT_RESET;
      state_reg.cs_n <= '1;
      state_reg.rd_n <= 1'b1;
      state_reg.we0_n <= 1'b1;
      state_reg.we1_n <= 1'b1;
      state_reg.data_oe_n <= 1'b1;
      state_reg.card <= '{ce1_n: 1'b1, ce2_n: 1'b1, noe_n: 1'b1, nwe_n: 1'b1,
                          niord_n: 1'b1, rnw: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  ebm_float_gap #(
    .FLOAT_W(FLOAT_W)
  ) u_gap (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(gap_start),
    .float_cycles_i(gap_cycles),
    .busy_o(gap_busy)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_dat_o = state_reg.rdata;
  assign wb_ack_o = state_reg.ack;
  assign ext_addr_o = state_reg.addr;
  assign ext_chip_select_n_o = state_reg.cs_n;
  assign ext_rd_n_o = state_reg.rd_n;
  assign ext_we0_n_o = state_reg.we0_n;
  assign ext_we1_n_o = state_reg.we1_n;
  assign ext_data_o = state_reg.data;
  assign ext_data_oe_n_o = state_reg.data_oe_n;
  assign card_o = state_reg.card;
  assign dram_enable_o = state_reg.select[EBM_DRAM_BIT];
  assign static_grant_o = state_reg.static_grant;
  assign nand_grant_o = state_reg.nand_grant;
  assign dram_irq_line_o = state_reg.dram_irq;
  assign ecc_irq_line_o = state_reg.ecc_irq;

endmodule : ebm_cs_mux
`default_nettype wire

// file: verification/ebm_cs_mux_assertions.sv
// Concurrent checks on the ports of the chip-select mux.
`timescale 1ns/10ps
`default_nettype none
module ebm_cs_mux_assertions
  import ebm_pkg::*;
#(
  parameter int FLOAT_W = EBM_FLOAT_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Controller side
  input wire ebm_pins_t static_pins_i,
  input wire ebm_pins_t dram_pins_i,
  input wire ebm_pins_t nand_pins_i,
  input wire logic dram_refresh_i,
  input wire logic dram_irq_i,
  // Pin side
  input wire logic [EBM_ADDR_W-1:0] ext_addr_o,
  input wire logic [EBM_NCS-1:0] ext_chip_select_n_o,
  input wire logic ext_rd_n_o,
  input wire logic ext_we0_n_o,
  input wire logic ext_data_oe_n_o,
  input wire logic static_grant_o,
  input wire logic nand_grant_o,
  input wire logic dram_irq_line_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic nobody;
  assign nobody = !static_pins_i.active && !nand_pins_i.active && !dram_pins_i.active;

  // A hand-over of the data pins is two steps: one owner drives, the next takes over.
  sequence s_static_drives;
    static_grant_o && !ext_data_oe_n_o;
  endsequence
  sequence s_nand_takes;
    s_static_drives ##1 nand_grant_o;
  endsequence

  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside acknowledge");
  a_idle_stable: assert property (nobody |=> &ext_chip_select_n_o && ext_rd_n_o && ext_we0_n_o && $stable(ext_addr_o))
    else $error("pins moved while no access runs");
  a_refresh_free: assert property (dram_pins_i.active && dram_refresh_i && !static_pins_i.active
                                   && !nand_pins_i.active |=> &ext_chip_select_n_o)
    else $error("refresh took the shared pins");
  a_static_wins: assert property (static_pins_i.active && !static_pins_i.cs_n[0]
                                  |=> static_grant_o && ext_addr_o == $past(static_pins_i.addr))
    else $error("static access on select zero not routed");
  a_float_hold: assert property (s_nand_takes |-> ext_data_oe_n_o)
    else $error("new owner drove data without float gap");
  a_irq_pass: assert property ($rose(dram_irq_i) |=> dram_irq_line_o)
    else $error("dram interrupt not passed on");
endmodule : ebm_cs_mux_assertions

bind ebm_cs_mux ebm_cs_mux_assertions #(.FLOAT_W(FLOAT_W)) ebm_cs_mux_assertions_inst (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o),
  .static_pins_i(static_pins_i),
  .dram_pins_i(dram_pins_i),
  .nand_pins_i(nand_pins_i),
  .dram_refresh_i(dram_refresh_i),
  .dram_irq_i(dram_irq_i),
  .ext_addr_o(ext_addr_o),
  .ext_chip_select_n_o(ext_chip_select_n_o),
  .ext_rd_n_o(ext_rd_n_o),
  .ext_we0_n_o(ext_we0_n_o),
  .ext_data_oe_n_o(ext_data_oe_n_o),
  .static_grant_o(static_grant_o),
  .nand_grant_o(nand_grant_o),
  .dram_irq_line_o(dram_irq_line_o)
);
`default_nettype wire

// file: verification/ebm_ext_dev.sv
// Far-side devices that note which chip-select lines they saw asserted.
`timescale 1ns/10ps
`default_nettype none
module ebm_ext_dev
  import ebm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [EBM_NCS-1:0] cs_n_i,
  output logic [EBM_NCS-1:0] seen_o
);
  // A device reacts only while its own select line is low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_o <= '0;
    end else begin
      seen_o <= seen_o | ~cs_n_i;
    end
  end
endmodule : ebm_ext_dev
`default_nettype wire

// file: verification/tb_ebm_cs_mux.sv
// Self-checking bench of the external bus chip-select mux.
`timescale 1ns/10ps
`default_nettype none
module tb_ebm_cs_mux
  import ebm_pkg::*;
;
  localparam logic [3:0] FL = 4'h3;
  localparam ebm_pins_t IDLE = {1'b0, 24'h0, 6'h3f, 4'hf, 16'h0};
  localparam logic [2:0] MODES [5] = '{EBM_MODE_ATTR, EBM_MODE_COMMON, EBM_MODE_IO,
                                       EBM_MODE_IDE, EBM_MODE_ALT_IDE};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_s = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  ebm_pins_t sp = IDLE;
  ebm_pins_t np = IDLE;
  ebm_pins_t dp = IDLE;
  logic rf = 1'b0;
  logic dirq = 1'b0;
  logic eirq = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [EBM_ADDR_W-1:0] ext_addr_o;
  logic [EBM_NCS-1:0] ext_chip_select_n_o;
  logic [EBM_NCS-1:0] seen;
  logic ext_rd_n_o;
  logic ext_we0_n_o;
  logic ext_we1_n_o;
  logic [EBM_DATA_W-1:0] ext_data_o;
  logic ext_data_oe_n_o;
  ebm_card_t card_o;
  logic dram_enable_o;
  logic static_grant_o;
  logic nand_grant_o;
  logic dram_irq_line_o;
  logic ecc_irq_line_o;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;

  ebm_cs_mux #(.FLOAT_W(EBM_FLOAT_W)) ebm_cs_mux_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req_s), .wb_stb_i(req_s), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .static_pins_i(sp), .dram_pins_i(dp), .nand_pins_i(np), .dram_refresh_i(rf),
    .static_float_i(FL), .dram_float_i(4'h2), .nand_float_i(4'h2), .dram_irq_i(dirq),
    .ecc_irq_i(eirq), .ext_addr_o(ext_addr_o), .ext_chip_select_n_o(ext_chip_select_n_o),
    .ext_rd_n_o(ext_rd_n_o), .ext_we0_n_o(ext_we0_n_o), .ext_we1_n_o(ext_we1_n_o),
    .ext_data_o(ext_data_o),
    .ext_data_oe_n_o(ext_data_oe_n_o), .card_o(card_o), .dram_enable_o(dram_enable_o),
    .static_grant_o(static_grant_o), .nand_grant_o(nand_grant_o),
    .dram_irq_line_o(dram_irq_line_o), .ecc_irq_line_o(ecc_irq_line_o));
  ebm_ext_dev ebm_ext_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(ext_chip_select_n_o),
    .seen_o(seen));

  always #50 clk_i = ~clk_i;
  // The whole run needs well under a thousand cycles.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      conclude();
    end
  end

  task conclude;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, g, e);
    end
  endtask : chk

  function automatic ebm_pins_t req(input int cs, input logic [23:0] a, input logic oe);
    req = {1'b1, a, ~(6'h01 << cs), 3'b011, oe, 16'h5a5a};
  endfunction : req

  function automatic logic [1:0] exp_strobe(input logic [2:0] m);
    case (m)
      EBM_MODE_IO: exp_strobe = 2'b10;
      EBM_MODE_IDE, EBM_MODE_ALT_IDE: exp_strobe = 2'b00;
      default: exp_strobe = 2'b01;
    endcase
  endfunction : exp_strobe

  // Expected {ce2_n, ce1_n, niord_n} for a read with byte lane zero selected.
  function automatic logic [2:0] exp_ce(input logic [2:0] m);
    case (m)
      EBM_MODE_IO, EBM_MODE_IDE: exp_ce = 3'b100;
      EBM_MODE_ALT_IDE: exp_ce = 3'b010;
      default: exp_ce = 3'b101;
    endcase
  endfunction : exp_ce

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    req_s <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Only the bench timeout ends a wait that never sees acknowledge.
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    req_s <= 1'b0;
  endtask : wb

  task settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle

  task go(input ebm_pins_t s, input ebm_pins_t n, input ebm_pins_t d);
    @(posedge clk_i);
    sp <= s;
    np <= n;
    dp <= d;
    settle();
  endtask : go

  task t_regs;
    logic [31:0] r;
    wb(1'b0, EBM_SELECT_OFFSET, 32'h0, r);
    chk(r, 32'h0);
    wb(1'b1, EBM_SELECT_OFFSET, 32'hffff_ffff, r);
    wb(1'b0, EBM_SELECT_OFFSET, 32'h0, r);
    chk(r, 32'h3e);
    wb(1'b0, 8'h08, 32'h0, r);
    chk(r, 32'h0);
  endtask : t_regs

  task t_route;
    logic [31:0] r;
    wb(1'b1, EBM_SELECT_OFFSET, 32'h2, r);
    go(IDLE, IDLE, req(1, 24'h000123, 1'b1));
    chk({dram_enable_o, ext_chip_select_n_o}, 32'h7d);
    chk(ext_addr_o, 32'h123);
    @(posedge clk_i);
    rf <= 1'b1;
    go(req(0, 24'h000456, 1'b1), IDLE, req(1, 24'h000123, 1'b1));
    chk(ext_chip_select_n_o, 32'h3e);
    wb(1'b0, EBM_STATUS_OFFSET, 32'h0, r);
    chk(r[0], 32'h1);
    @(posedge clk_i);
    rf <= 1'b0;
    wb(1'b1, EBM_SELECT_OFFSET, 32'h0, r);
    go(IDLE, IDLE, req(1, 24'h000123, 1'b1));
    chk(ext_chip_select_n_o, 32'h3f);
    for (int c = 2; c < 4; c++) begin
      wb(1'b1, EBM_SELECT_OFFSET, 32'h1 << c, r);
      go(req(c, 24'h0000aa, 1'b1), req(c, 24'h0000bb, 1'b1), IDLE);
      chk({nand_grant_o, ext_addr_o}, {8'h1, 24'hbb});
      wb(1'b1, EBM_SELECT_OFFSET, 32'h0, r);
      go(req(c, 24'h0000aa, 1'b1), req(c, 24'h0000bb, 1'b1), IDLE);
      chk({static_grant_o, ext_addr_o}, {8'h1, 24'haa});
      chk({ext_rd_n_o, ext_we0_n_o, ext_we1_n_o, ext_data_o}, {3'b011, 16'h5a5a});
    end
  endtask : t_route

  task t_card;
    logic [31:0] r;
    for (int c = 4; c < 6; c++) begin
      wb(1'b1, EBM_SELECT_OFFSET, 32'h1 << c, r);
      foreach (MODES[i]) begin
        go(req(c, {MODES[i], 21'h0}, 1'b1), IDLE, IDLE);
        chk({ext_rd_n_o, card_o.noe_n, card_o.niord_n}, {1'b1, exp_strobe(MODES[i])});
        chk({card_o.ce2_n, card_o.ce1_n, ext_we1_n_o, ext_we0_n_o, card_o.nwe_n, card_o.rnw},
            {exp_ce(MODES[i]), 3'b111});
      end
      chk(seen[c], 32'h1);
      wb(1'b1, EBM_SELECT_OFFSET, (32'h1 << c) | 32'h2, r);
      go(IDLE, IDLE, req(c, 24'h000077, 1'b1));
      chk(ext_chip_select_n_o, 32'h3f);
      go(req(0, {EBM_MODE_IO, 21'h0}, 1'b1), IDLE, IDLE);
      chk({ext_rd_n_o, card_o.niord_n}, 32'h1);
      wb(1'b1, EBM_SELECT_OFFSET, 32'h0, r);
      go(req(c, {EBM_MODE_IO, 21'h0}, 1'b1), IDLE, IDLE);
      chk({ext_rd_n_o, card_o.niord_n}, 32'h1);
    end
  endtask : t_card

  task t_float;
    logic [31:0] r;
    int n;
    n = 0;
    go(req(0, 24'h000010, 1'b0), IDLE, IDLE);
    wb(1'b1, EBM_SELECT_OFFSET, 32'h4, r);
    @(posedge clk_i);
    sp <= IDLE;
    np <= req(2, 24'h000020, 1'b0);
    @(posedge clk_i);
    #1;
    while (ext_data_oe_n_o === 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
      #1;
    end
    chk(n >= FL + 1 && n <= FL + 2, 32'h1);
    go(IDLE, IDLE, IDLE);
  endtask : t_float

  task t_irq;
    @(posedge clk_i);
    dirq <= 1'b1;
    eirq <= 1'b1;
    settle();
    chk({dram_irq_line_o, ecc_irq_line_o}, 32'h3);
    @(posedge clk_i);
    dirq <= 1'b0;
    settle();
    chk({dram_irq_line_o, ecc_irq_line_o}, 32'h1);
  endtask : t_irq

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_route();
    t_card();
    t_float();
    t_irq();
    conclude();
  end
endmodule : tb_ebm_cs_mux
`default_nettype wire
